// ### verilog/ioi_pkg.sv
// Shared constants for the process image link: assembly ids, codes, timings, register map.
// Assumes a single 250 MHz core clock on both ends.
package ioi_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int ACCEPT_MS = 350;
  localparam int RING_US = 3000;
  // Accept time converts exactly; ring must finish strictly under its figure
  localparam int ACCEPT_CYC = ACCEPT_MS * 1000 * CLK_MHZ;
  localparam int RING_CYC = RING_US * CLK_MHZ - 1;

  // ****************************************
  // Assemblies and images
  // ****************************************
  localparam logic [7:0] ASM_OUT = 8'h64;
  localparam logic [7:0] ASM_IN = 8'h65;
  localparam logic [7:0] ASM_CFG = 8'h66;
  localparam logic [7:0] ASM_HB_IO = 8'hc1;
  localparam logic [7:0] ASM_HB_LO = 8'hc0;
  localparam int IN_W = 40;
  localparam int STAT_W = 32;
  localparam int DIAG_W = 6;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_ONE = 8'h01;
  localparam logic [7:0] SUB_HOLD = 8'h02;
  localparam logic [7:0] SUB_PATTERN = 8'h03;
  localparam logic [7:0] CFG_MODE_RST = 8'h00;
  localparam logic [7:0] CFG_PAT_RST = 8'h00;
  localparam logic [3:0] ROT_DEFAULTS = 4'hf;

  typedef enum logic [1:0] {CT_OWNER, CT_INONLY, CT_LISTEN, CT_BAD} ioi_conn_t;

  function automatic logic [7:0] out_asm(input ioi_conn_t t);
    case (t)
      CT_OWNER: out_asm = ASM_OUT;
      CT_INONLY: out_asm = ASM_HB_IO;
      default: out_asm = ASM_HB_LO;
    endcase
  endfunction

  function automatic logic cfg_expected(input ioi_conn_t t);
    cfg_expected = (t == CT_OWNER) || (t == CT_INONLY);
  endfunction

  // ****************************************
  // Scanner register map
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_OUT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_IN_STAT = 8'h10;
  localparam logic [7:0] REG_IN_DATA = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1c;
  localparam int CB_OPEN = 0;
  localparam int CB_CLOSE = 1;
  localparam int CB_POLL = 2;
  localparam int CB_SEND = 3;
  localparam int CB_TYPE = 4;
  localparam int CB_MCAST = 6;
  localparam int SB_READY = 0;
  localparam int SB_UP = 1;
  localparam int IB_ACK = 0;
  localparam int IB_NAK = 1;
  localparam int IB_IN = 2;
  localparam int IB_DOWN = 3;
  localparam int IRQ_W = 4;
endpackage

// ### verilog/ioi_link_if.sv
// Cyclic process data link between scanner and field device.
// Both ends share one clock; every signal is a flip-flop or, for req_mcast, req_cfg, out_asm and out_data, decoded from flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface ioi_link_if;
  logic req_open;
  logic req_close;
  ioi_pkg::ioi_conn_t req_type;
  logic req_mcast;
  logic req_cfg;
  logic [7:0] cfg_mode;
  logic [7:0] cfg_pattern;
  logic out_valid;
  logic [7:0] out_asm;
  logic [7:0] out_data;
  logic in_poll;
  logic dev_ready;
  logic conn_ack;
  logic conn_nak;
  logic conn_up;
  logic in_valid;
  logic [7:0] in_asm;
  logic [ioi_pkg::IN_W-1:0] in_data;

  modport dev(input req_open, req_close, req_type, req_mcast, req_cfg, cfg_mode, cfg_pattern,
              out_valid, out_asm, out_data, in_poll,
              output dev_ready, conn_ack, conn_nak, conn_up, in_valid, in_asm, in_data);
  modport scn(output req_open, req_close, req_type, req_mcast, req_cfg, cfg_mode, cfg_pattern,
              out_valid, out_asm, out_data, in_poll,
              input dev_ready, conn_ack, conn_nak, conn_up, in_valid, in_asm, in_data);
endinterface
`default_nettype wire

// ### verilog/ioi_subst.sv
// Output value selection: live data or the configured substitute.
// Assumes the caller registers the result and feeds it back as last_i.
`timescale 1ns/1ps
`default_nettype none
module ioi_subst (
  input wire logic data_ok_i,      // Valid cyclic output data present
  input wire logic [7:0] live_i,   // Latest output byte
  input wire logic [7:0] last_i,   // Outputs as currently driven
  input wire logic [7:0] mode_i,   // Substitute behaviour code
  input wire logic [7:0] pat_i,    // Substitute pattern
  output logic [7:0] value_o       // Next output value
);
  always_comb begin
    if (data_ok_i) begin
      value_o = live_i;
    end else begin
      case (mode_i)
        ioi_pkg::SUB_ONE: value_o = 8'hff;
        ioi_pkg::SUB_HOLD: value_o = last_i;
        ioi_pkg::SUB_PATTERN: value_o = pat_i;
        default: value_o = 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### verilog/ioi_device.sv
// Field device end: output byte to eight outputs, five-byte input image, substitute values.
// Assumes the scanner end keeps its side of the link; all inputs synchronous to clock_i.
//
// Contract
// - All connections carry five-byte input image 101
// - Owner outputs via 100; heartbeats 193, 192
// - Owner and input-only send configuration 102
// - Output bit k drives output k+1
// - Status word bytes 0-3, inputs byte 4
// - Status bits: outputs, actuator, sensor supply faults
// - Input byte bit k is input k+1
// - Config byte 0: zero, one, hold, pattern
// - Config byte 1 pattern used in mode 3
// - Accept requests within 350 ms, connect 500
// - Listen-only multicast; others multicast or point-to-point
// - Ring reconfiguration under 3 ms, one ring
// - Switch position 0F restores factory defaults
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ioi_device #(
  parameter int BOOT_CYC = ioi_pkg::ACCEPT_CYC,   // Cycles until requests are accepted
  parameter int RING_CYCLES = ioi_pkg::RING_CYC   // Cycles for ring reconfiguration
) (
  input wire logic clock_i,                       // Core clock, 250 MHz
  input wire logic resetn_i,                      // Sync reset, active low
  ioi_link_if.dev link,                           // Link to scanner
  input wire logic [7:0] device_input_channel_i,  // Input levels, bit k = input k+1
  input wire logic [ioi_pkg::DIAG_W-1:0] diag_i,  // Fault flags in status bit order
  input wire logic [3:0] rot_sw_i,                // Rotary coding switch
  input wire logic link_lost_i,                   // Connection loss from network side
  input wire logic ring_break_i,                  // Ring break detected, pulse
  output logic [7:0] dout_o,                      // Outputs, bit k = output k+1
  output logic out_live_o,                        // Outputs follow live data
  output logic ring_fault_o,                      // Ring reconfiguring
  output logic ring_reconf_o                      // Ring restored, pulse
);
  typedef enum logic {S_IDLE, S_UP} ioi_state_t;

  ioi_state_t state_q;
  ioi_pkg::ioi_conn_t type_q;
  logic [31:0] boot_cnt_q;
  logic ready_q;
  logic ack_q;
  logic nak_q;
  logic up_q;
  logic [7:0] mode_q;
  logic [7:0] pat_q;
  logic [7:0] live_q;
  logic data_ok_q;
  logic [7:0] dout_q;
  logic [7:0] dout_d;
  logic in_valid_q;
  logic [7:0] in_asm_q;
  logic [ioi_pkg::IN_W-1:0] in_data_q;
  logic [31:0] ring_cnt_q;
  logic ring_fault_q;
  logic ring_reconf_q;
  logic req_ok;
  logic drop;
  logic defaults;
  logic [ioi_pkg::STAT_W-1:0] status;

  // ****************************************
  // Startup
  // ****************************************
  // Requests are refused until the boot interval has elapsed
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      boot_cnt_q <= 32'h0;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      boot_cnt_q <= boot_cnt_q + 32'h1;
      ready_q <= (boot_cnt_q >= 32'(BOOT_CYC - 1));
    end
  end

  // ****************************************
  // Connection handling
  // ****************************************
  assign defaults = (rot_sw_i == ioi_pkg::ROT_DEFAULTS);
  assign drop = link.req_close || link_lost_i;

  always_comb begin
    req_ok = ready_q && (state_q == S_IDLE) && (link.req_type != ioi_pkg::CT_BAD);
    // Configuration image present exactly for owner and input-only
    if (link.req_cfg != ioi_pkg::cfg_expected(link.req_type)) begin
      req_ok = 1'b0;
    end
    if ((link.req_type == ioi_pkg::CT_LISTEN) && !link.req_mcast) begin
      req_ok = 1'b0;
    end
    if (link.req_cfg && (link.cfg_mode > ioi_pkg::SUB_PATTERN)) begin
      req_ok = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= S_IDLE;
      type_q <= ioi_pkg::CT_OWNER;
      up_q <= 1'b0;
      ack_q <= 1'b0;
      nak_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      nak_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (link.req_open && req_ok) begin
            state_q <= S_UP;
            type_q <= link.req_type;
            up_q <= 1'b1;
            ack_q <= 1'b1;
          end else if (link.req_open) begin
            nak_q <= 1'b1;
          end
        end
        S_UP: begin
          if (drop) begin
            state_q <= S_IDLE;
            up_q <= 1'b0;
          end else if (link.req_open) begin
            // A single connection at a time; further requests are refused
            nak_q <= 1'b1;
          end
        end
        default: begin
          state_q <= S_IDLE;
          up_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Configuration image
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mode_q <= ioi_pkg::CFG_MODE_RST;
      pat_q <= ioi_pkg::CFG_PAT_RST;
    end else if (defaults) begin
      mode_q <= ioi_pkg::CFG_MODE_RST;
      pat_q <= ioi_pkg::CFG_PAT_RST;
    end else if (link.req_open && req_ok && link.req_cfg) begin
      mode_q <= link.cfg_mode;
      pat_q <= link.cfg_pattern;
    end
  end

  // ****************************************
  // Output image
  // ****************************************
  // Only the owner's assembly carries data; heartbeats refresh nothing
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      live_q <= 8'h00;
      data_ok_q <= 1'b0;
    end else if ((state_q != S_UP) || drop) begin
      data_ok_q <= 1'b0;
    end else if (link.out_valid && (type_q == ioi_pkg::CT_OWNER)
                 && (link.out_asm == ioi_pkg::out_asm(type_q))) begin
      live_q <= link.out_data;
      data_ok_q <= 1'b1;
    end
  end

  ioi_subst u_subst (
    .data_ok_i(data_ok_q),
    .live_i(live_q),
    .last_i(dout_q),
    .mode_i(mode_q),
    .pat_i(pat_q),
    .value_o(dout_d)
  );

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dout_q <= 8'h00;
    end else begin
      dout_q <= dout_d;
    end
  end

  // ****************************************
  // Input image
  // ****************************************
  always_comb begin
    status = '0;
    status[ioi_pkg::DIAG_W-1:0] = diag_i;
  end

  // Every connection type polls the same five-byte assembly
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      in_valid_q <= 1'b0;
      in_asm_q <= 8'h00;
      in_data_q <= '0;
    end else begin
      in_valid_q <= link.in_poll && up_q;
      if (link.in_poll && up_q) begin
        in_asm_q <= ioi_pkg::ASM_IN;
        in_data_q <= {device_input_channel_i, status};
      end
    end
  end

  // ****************************************
  // Ring recovery
  // ****************************************
  // A new break while reconfiguring restarts the interval
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ring_fault_q <= 1'b0;
      ring_cnt_q <= 32'h0;
      ring_reconf_q <= 1'b0;
    end else begin
      ring_reconf_q <= 1'b0;
      if (ring_break_i) begin
        ring_fault_q <= 1'b1;
        ring_cnt_q <= 32'h0;
      end else if (ring_fault_q) begin
        ring_cnt_q <= ring_cnt_q + 32'h1;
        if (ring_cnt_q >= 32'(RING_CYCLES - 1)) begin
          ring_fault_q <= 1'b0;
          ring_reconf_q <= 1'b1;
        end
      end
    end
  end

  assign link.dev_ready = ready_q;
  assign link.conn_ack = ack_q;
  assign link.conn_nak = nak_q;
  assign link.conn_up = up_q;
  assign link.in_valid = in_valid_q;
  assign link.in_asm = in_asm_q;
  assign link.in_data = in_data_q;
  assign dout_o = dout_q;
  assign out_live_o = data_ok_q;
  assign ring_fault_o = ring_fault_q;
  assign ring_reconf_o = ring_reconf_q;
endmodule
`default_nettype wire

// ### verilog/ioi_scanner.sv
// Scanner end: AHB-Lite register slave that opens connections and moves process images.
// Assumes a single AHB-Lite master, word transfers only, device on the link.
`timescale 1ns/1ps
`default_nettype none
module ioi_scanner (
  input wire logic clock_i,          // Core clock, 250 MHz
  input wire logic resetn_i,         // Sync reset, active low
  input wire logic hsel_i,           // AHB select
  input wire logic [31:0] haddr_i,   // AHB address
  input wire logic [1:0] htrans_i,   // AHB transfer type
  input wire logic hwrite_i,         // AHB write
  input wire logic [2:0] hsize_i,    // AHB size, word only
  input wire logic [31:0] hwdata_i,  // AHB write data
  input wire logic hready_i,         // AHB ready in
  output logic [31:0] hrdata_o,      // AHB read data
  output logic hreadyout_o,          // AHB ready out
  output logic hresp_o,              // AHB response, always OKAY
  output logic irq_o,                // Interrupt, active high level
  ioi_link_if.scn link               // Link to device
);
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;
  logic [31:0] rd;
  logic take;
  logic wr_ctrl;
  ioi_pkg::ioi_conn_t type_q;
  logic mcast_q;
  logic [7:0] mode_q;
  logic [7:0] pat_q;
  logic [7:0] out_q;
  logic open_q;
  logic close_q;
  logic poll_q;
  logic send_q;
  logic [31:0] in_stat_q;
  logic [7:0] in_byte_q;
  logic up_q;
  logic [ioi_pkg::IRQ_W-1:0] ist_q;
  logic [ioi_pkg::IRQ_W-1:0] imask_q;
  logic [ioi_pkg::IRQ_W-1:0] iev;
  logic irq_q;

  // ****************************************
  // Bus slave
  // ****************************************
  assign take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);

  always_comb begin
    case (haddr_i[7:0])
      ioi_pkg::REG_CTRL: rd = {25'h0, mcast_q, type_q, 4'h0};
      ioi_pkg::REG_CFG: rd = {16'h0, pat_q, mode_q};
      ioi_pkg::REG_OUT: rd = {24'h0, out_q};
      ioi_pkg::REG_STAT: rd = {30'h0, link.conn_up, link.dev_ready};
      ioi_pkg::REG_IN_STAT: rd = in_stat_q;
      ioi_pkg::REG_IN_DATA: rd = {24'h0, in_byte_q};
      ioi_pkg::REG_IRQ_STAT: rd = {28'h0, ist_q};
      ioi_pkg::REG_IRQ_MASK: rd = {28'h0, imask_q};
      default: rd = 32'h0;
    endcase
  end

  // Read data is fetched in the address phase, so no wait states are needed
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      wr_q <= take && hwrite_i;
      if (take) begin
        waddr_q <= haddr_i[7:0];
      end
      if (take && !hwrite_i) begin
        rdata_q <= rd;
      end
    end
  end

  assign wr_ctrl = wr_q && (waddr_q == ioi_pkg::REG_CTRL);

  // ****************************************
  // Settings and commands
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      type_q <= ioi_pkg::CT_OWNER;
      mcast_q <= 1'b0;
      mode_q <= ioi_pkg::CFG_MODE_RST;
      pat_q <= ioi_pkg::CFG_PAT_RST;
      out_q <= 8'h00;
      imask_q <= '0;
    end else if (wr_q) begin
      case (waddr_q)
        ioi_pkg::REG_CTRL: begin
          type_q <= ioi_pkg::ioi_conn_t'(hwdata_i[ioi_pkg::CB_TYPE +: 2]);
          mcast_q <= hwdata_i[ioi_pkg::CB_MCAST];
        end
        ioi_pkg::REG_CFG: begin
          mode_q <= hwdata_i[7:0];
          pat_q <= hwdata_i[15:8];
        end
        ioi_pkg::REG_OUT: out_q <= hwdata_i[7:0];
        ioi_pkg::REG_IRQ_MASK: imask_q <= hwdata_i[ioi_pkg::IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Command bits act once; the type written with them already applies
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      open_q <= 1'b0;
      close_q <= 1'b0;
      poll_q <= 1'b0;
      send_q <= 1'b0;
    end else begin
      open_q <= wr_ctrl && hwdata_i[ioi_pkg::CB_OPEN];
      close_q <= wr_ctrl && hwdata_i[ioi_pkg::CB_CLOSE];
      poll_q <= wr_ctrl && hwdata_i[ioi_pkg::CB_POLL];
      send_q <= wr_ctrl && hwdata_i[ioi_pkg::CB_SEND];
    end
  end

  // ****************************************
  // Input image capture and events
  // ****************************************
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      in_stat_q <= 32'h0;
      in_byte_q <= 8'h00;
      up_q <= 1'b0;
    end else begin
      up_q <= link.conn_up;
      if (link.in_valid && (link.in_asm == ioi_pkg::ASM_IN)) begin
        in_stat_q <= link.in_data[ioi_pkg::STAT_W-1:0];
        in_byte_q <= link.in_data[ioi_pkg::IN_W-1:ioi_pkg::STAT_W];
      end
    end
  end

  always_comb begin
    iev = '0;
    iev[ioi_pkg::IB_ACK] = link.conn_ack;
    iev[ioi_pkg::IB_NAK] = link.conn_nak;
    iev[ioi_pkg::IB_IN] = link.in_valid;
    iev[ioi_pkg::IB_DOWN] = up_q && !link.conn_up;
  end

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (wr_q && (waddr_q == ioi_pkg::REG_IRQ_STAT)) begin
        ist_q <= (ist_q & ~hwdata_i[ioi_pkg::IRQ_W-1:0]) | iev;
      end else begin
        ist_q <= ist_q | iev;
      end
      irq_q <= |(ist_q & imask_q);
    end
  end

  // ****************************************
  // Link drive
  // ****************************************
  assign link.req_open = open_q;
  assign link.req_close = close_q;
  assign link.req_type = type_q;
  assign link.req_mcast = (type_q == ioi_pkg::CT_LISTEN) ? 1'b1 : mcast_q;
  assign link.req_cfg = ioi_pkg::cfg_expected(type_q);
  assign link.cfg_mode = mode_q;
  assign link.cfg_pattern = pat_q;
  assign link.out_valid = send_q;
  assign link.out_asm = ioi_pkg::out_asm(type_q);
  assign link.out_data = (type_q == ioi_pkg::CT_OWNER) ? out_q : 8'h00;
  assign link.in_poll = poll_q;
  assign hrdata_o = rdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign irq_o = irq_q;
endmodule
`default_nettype wire

// ### tb/ioi_link_assertions.sv
// Checker for the scanner to device link: request, answer and image relations.
// Assumes one shared clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ioi_link_assertions (
  input wire logic clock_i, // Clock
  input wire logic resetn_i, // Reset, low
  input wire logic req_open, // Open
  input wire logic req_close, // Close
  input wire ioi_pkg::ioi_conn_t req_type, // Type
  input wire logic req_mcast, // Multicast
  input wire logic req_cfg, // Config present
  input wire logic [7:0] cfg_mode, // Mode
  input wire logic out_valid, // Out strobe
  input wire logic [7:0] out_asm, // Out assembly
  input wire logic [7:0] out_data, // Out byte
  input wire logic in_poll, // Poll
  input wire logic dev_ready, // Ready
  input wire logic conn_ack, // Ack
  input wire logic conn_nak, // Nak
  input wire logic conn_up, // Up
  input wire logic in_valid, // In strobe
  input wire logic [7:0] in_asm // In assembly
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ****
  // Link relations
  // ****
  a_open_answer: assert property (req_open |=> conn_ack ^ conn_nak)
    else $error("open not answered");
  a_answer_cause: assert property ((conn_ack || conn_nak) |-> $past(req_open))
    else $error("answer without open");
  a_boot_refuse: assert property (req_open && !dev_ready |=> conn_nak)
    else $error("open accepted before ready");
  a_bad_type: assert property (req_open && req_type == ioi_pkg::CT_BAD |=> conn_nak)
    else $error("illegal type accepted");
  a_mode_range: assert property (req_open && req_cfg && cfg_mode > 8'h03 |=> conn_nak)
    else $error("mode above 3 accepted");
  a_cfg_image: assert property (req_open && req_type != ioi_pkg::CT_BAD |->
      req_cfg == (req_type == ioi_pkg::CT_OWNER || req_type == ioi_pkg::CT_INONLY))
    else $error("config image presence wrong");
  a_listen_mcast: assert property (req_open && req_type == ioi_pkg::CT_LISTEN |-> req_mcast)
    else $error("listen-only not multicast");
  a_up_on_ack: assert property ($rose(conn_up) |-> conn_ack)
    else $error("up without ack");
  a_close_drop: assert property (conn_up && req_close |=> !conn_up)
    else $error("close did not drop");
  a_poll_image: assert property (in_poll && conn_up |=> in_valid && in_asm == 8'h65)
    else $error("poll answer wrong");
  a_heartbeat: assert property (out_valid && out_asm != 8'h64 |-> out_data == 8'h00)
    else $error("heartbeat carries data");
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Bench: scanner and device joined by the link, scanner driven over AHB-Lite.
// Assumes shortened boot and ring counts; read results checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int BOOT = 20;
  localparam int RING = 10;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] din = 8'h00;
  logic [5:0] diag = 6'h00;
  logic [3:0] rot = 4'h0;
  logic lost = 1'b0;
  logic brk = 1'b0;
  logic rd_q = 1'b0;
  logic [31:0] hrdata;
  logic [31:0] lfsr;
  logic [7:0] dout, last, pat, byt;
  logic hready, hresp, irq, rfault, rdone, live;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  ioi_link_if ioi_link_if_i ();
  ioi_scanner ioi_scanner_i (.clock_i(clock_i), .resetn_i(resetn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .irq_o(irq),
    .link(ioi_link_if_i.scn));
  ioi_device #(.BOOT_CYC(BOOT), .RING_CYCLES(RING)) ioi_device_i (.clock_i(clock_i),
    .resetn_i(resetn_i), .link(ioi_link_if_i.dev), .device_input_channel_i(din),
    .diag_i(diag), .rot_sw_i(rot), .link_lost_i(lost), .ring_break_i(brk), .dout_o(dout),
    .out_live_o(live), .ring_fault_o(rfault), .ring_reconf_o(rdone));
  ioi_link_assertions ioi_link_assertions_i (.clock_i(clock_i), .resetn_i(resetn_i),
    .req_open(ioi_link_if_i.req_open), .req_close(ioi_link_if_i.req_close),
    .req_type(ioi_link_if_i.req_type), .req_mcast(ioi_link_if_i.req_mcast),
    .req_cfg(ioi_link_if_i.req_cfg), .cfg_mode(ioi_link_if_i.cfg_mode),
    .out_valid(ioi_link_if_i.out_valid), .out_asm(ioi_link_if_i.out_asm),
    .out_data(ioi_link_if_i.out_data), .in_poll(ioi_link_if_i.in_poll),
    .dev_ready(ioi_link_if_i.dev_ready), .conn_ack(ioi_link_if_i.conn_ack),
    .conn_nak(ioi_link_if_i.conn_nak), .conn_up(ioi_link_if_i.conn_up),
    .in_valid(ioi_link_if_i.in_valid), .in_asm(ioi_link_if_i.in_asm));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] sub(input int m, input logic [7:0] l, input logic [7:0] p);
    case (m)
      0: sub = 8'h00;
      1: sub = 8'hff;
      2: sub = l;
      default: sub = p;
    endcase
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reads push their expectation; the monitor pops it in the data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clock_i);
    while (hready !== 1'b1) @(posedge clock_i);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wr ? d : 32'h0;
    if (!wr) begin
      exp_q.push_back(d);
      rd_q <= 1'b1;
    end
    @(posedge clock_i);
    while (hready !== 1'b1) @(posedge clock_i);
    rd_q <= 1'b0;
  endtask
  task automatic opn(input logic [1:0] t, input logic mc);
    ahb(1'b1, ioi_pkg::REG_CTRL, {25'h0, mc, t, 4'h1});
  endtask
  task automatic cmd(input logic [3:0] b);
    ahb(1'b1, ioi_pkg::REG_CTRL, {28'h0, b});
  endtask
  task automatic wt();
    repeat (6) @(posedge clock_i);
  endtask

  always @(posedge clock_i) begin
    if (rd_q && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check(32'(hresp), 32'h0);
    end
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    forever #2 clock_i = ~clock_i;
  end

  // ****
  // Scenarios
  // ****
  initial begin
    lfsr = 32'hde5a0d18;
    last = 8'h00;
    repeat (3) @(posedge clock_i);
    resetn_i <= 1'b1;
    ahb(1'b0, ioi_pkg::REG_STAT, 32'h0);
    ahb(1'b1, ioi_pkg::REG_IRQ_MASK, 32'h2);
    opn(2'd0, 1'b0);
    wt();
    check(32'(irq), 32'h1);
    ahb(1'b0, ioi_pkg::REG_IRQ_STAT, 32'h2);
    ahb(1'b1, ioi_pkg::REG_IRQ_STAT, 32'hf);
    wt();
    check(32'(irq), 32'h0);
    check(32'(dout), 32'h0);
    repeat (BOOT) @(posedge clock_i);
    ahb(1'b0, ioi_pkg::REG_STAT, 32'h1);
    $display("test early done");
    for (int m = 0; m < 4; m++) begin
      lfsr = nxt(lfsr);
      pat = lfsr[7:0];
      byt = lfsr[15:8];
      ahb(1'b1, ioi_pkg::REG_CFG, {16'h0, pat, 8'(m)});
      opn(2'd0, 1'b0);
      wt();
      check(32'(irq), 32'h0);
      last = sub(m, last, pat);
      check(32'(dout), 32'(last));
      ahb(1'b1, ioi_pkg::REG_OUT, {24'h0, byt});
      cmd(4'h8);
      wt();
      check(32'(dout), 32'(byt));
      check(32'(live), 32'h1);
      if (m == 3) lost <= 1'b1;
      else cmd(4'h2);
      wt();
      lost <= 1'b0;
      last = sub(m, byt, pat);
      check(32'(dout), 32'(last));
      check(32'(live), 32'h0);
    end
    $display("test substitute done");
    for (int t = 0; t < 3; t++) begin
      lfsr = nxt(lfsr);
      din <= lfsr[7:0];
      diag <= lfsr[13:8];
      opn(2'(t), t == 2);
      cmd(4'h8);
      wt();
      check(32'(dout), 32'((t == 0) ? byt : pat));
      cmd(4'h4);
      wt();
      ahb(1'b0, ioi_pkg::REG_IN_STAT, {26'h0, diag});
      ahb(1'b0, ioi_pkg::REG_IN_DATA, {24'h0, din});
      cmd(4'h2);
      wt();
    end
    $display("test images done");
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, ioi_pkg::REG_IRQ_STAT, 32'hf);
      ahb(1'b1, ioi_pkg::REG_CFG, (i == 1) ? 32'h4 : 32'h0);
      opn((i == 1) ? 2'd0 : 2'd3, 1'b0);
      wt();
      ahb(1'b0, ioi_pkg::REG_IRQ_STAT, 32'h2);
    end
    $display("test refusals done");
    ahb(1'b1, ioi_pkg::REG_CFG, 32'h1);
    opn(2'd0, 1'b0);
    wt();
    check(32'(dout), 32'hff);
    rot <= 4'hf;
    wt();
    check(32'(dout), 32'h0);
    rot <= 4'h0;
    cmd(4'h2);
    wt();
    check(32'(dout), 32'h0);
    $display("test switch done");
    brk <= 1'b1;
    @(posedge clock_i);
    brk <= 1'b0;
    @(posedge clock_i);
    check(32'(rfault), 32'h1);
    n = 0;
    while (rdone !== 1'b1 && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    check(32'(n <= RING), 32'h1);
    check(32'(rfault), 32'h0);
    $display("test ring done");
    end_of_test();
  end
endmodule
`default_nettype wire
